// ### logic/dpsem_cfg.svh
// Constants for the semaphore port controller
`ifndef DPSEM_CFG_SVH
`define DPSEM_CFG_SVH
`define DPSEM_FLAGS 8
`define DPSEM_IDX_W 3
`define DPSEM_ADDR_W 13
`define DPSEM_DATA_W 16
`define DPSEM_CLK_NS 50
`define DPSEM_SETUP_NS 50
`define DPSEM_PULSE_NS 100
`define DPSEM_GAP_NS 50
`define DPSEM_CYC(ns) (((ns) + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_SETUP_CYC `DPSEM_CYC(`DPSEM_SETUP_NS)
`define DPSEM_PULSE_CYC `DPSEM_CYC(`DPSEM_PULSE_NS)
`define DPSEM_GAP_CYC `DPSEM_CYC(`DPSEM_GAP_NS)
`define DPSEM_CNT_W 4
`define DPSEM_CMD_ACQUIRE 2'h0
`define DPSEM_CMD_RELEASE 2'h1
`define DPSEM_CMD_POLL 2'h2
`define DPSEM_CMD_INIT 2'h3
`endif

// ### logic/dpsem_pkg.sv
// Types for the semaphore port controller
package dpsem_pkg;
   typedef enum logic [1:0] {
      dpsem_acquire, dpsem_release, dpsem_poll, dpsem_init
   } dpsem_cmd_e;
   typedef struct packed {
      logic flag_space_select_n;
      logic array_select_n;
      logic output_enable_n;
      logic write_n;
      logic [12:0] addr;
      logic [15:0] wdata;
      logic data_oe;
   } dpsem_pins_s;
endpackage

// ### logic/dpsem_timer.sv
// Phase timer for one bus cycle phase
`timescale 1ns/100ps
`include "dpsem_cfg.svh"
module dpsem_timer (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [`DPSEM_CNT_W-1:0] load_val,
   output logic done
);
   logic [`DPSEM_CNT_W-1:0] cnt_r;
   logic [`DPSEM_CNT_W-1:0] cnt_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != 4'h0) begin
         cnt_nxt = cnt_r - 4'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign done = (cnt_r == 4'h0);
endmodule // dpsem_timer

// ### logic/dpsem_host.sv
// Host-side controller that drives one port of the semaphore flag space
`timescale 1ns/100ps
`include "dpsem_cfg.svh"
module dpsem_host (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input wire dpsem_pkg::dpsem_cmd_e cmd_op,
   input wire logic [`DPSEM_IDX_W-1:0] cmd_flag_index,
   output logic cmd_ready,
   output logic done_pulse,
   output logic done_granted,
   output logic [`DPSEM_DATA_W-1:0] done_rdata,
   output logic flag_space_select_n,
   output logic array_select_n,
   output logic output_enable_n,
   output logic write_n,
   output logic [`DPSEM_ADDR_W-1:0] addr,
   output logic [`DPSEM_DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic [`DPSEM_DATA_W-1:0] data_in
);
   typedef enum logic [2:0] {
      st_idle, st_wsetup, st_wpulse, st_wgap, st_rsetup, st_rsample, st_rgap, st_done
   } dpsem_state_e;

   function automatic logic [`DPSEM_CNT_W-1:0] dpsem_cnt(input int cyc);
      dpsem_cnt = (cyc < 1) ? 4'h0 : 4'(cyc - 1);
   endfunction

   function automatic logic [`DPSEM_IDX_W-1:0] dpsem_first_idx(input dpsem_pkg::dpsem_cmd_e op,
         input logic [`DPSEM_IDX_W-1:0] idx);
      dpsem_first_idx = (op == dpsem_pkg::dpsem_init) ? 3'h0 : idx; // Init always starts at flag zero
   endfunction

   function automatic logic [`DPSEM_ADDR_W-1:0] dpsem_flag_addr(input logic [`DPSEM_IDX_W-1:0] idx);
      dpsem_flag_addr = {10'h000, idx};
   endfunction

   dpsem_state_e state_r, state_nxt;
   dpsem_pkg::dpsem_pins_s pins_r, pins_nxt;
   dpsem_pkg::dpsem_cmd_e op_r, op_nxt;
   logic [`DPSEM_IDX_W-1:0] idx_r, idx_nxt;
   logic [`DPSEM_DATA_W-1:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt;
   logic done_r, done_nxt;
   logic granted_r, granted_nxt;
   logic tmr_load;
   logic [`DPSEM_CNT_W-1:0] tmr_val;
   logic tmr_done;

   dpsem_timer u_timer (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   always_comb begin
      state_nxt = state_r;
      pins_nxt = pins_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      rdata_nxt = rdata_r;
      ready_nxt = 1'b0;
      done_nxt = 1'b0;
      granted_nxt = granted_r;
      tmr_load = 1'b0;
      tmr_val = 4'h0;
      pins_nxt.array_select_n = 1'b1;
      unique case (state_r)
         st_idle: begin
            pins_nxt.flag_space_select_n = 1'b1;
            pins_nxt.output_enable_n = 1'b1;
            pins_nxt.write_n = 1'b1;
            pins_nxt.data_oe = 1'b0;
            ready_nxt = 1'b1;
            if (cmd_valid && ready_r) begin
               ready_nxt = 1'b0;
               op_nxt = cmd_op;
               idx_nxt = dpsem_first_idx(cmd_op, cmd_flag_index);
               pins_nxt.addr = dpsem_flag_addr(dpsem_first_idx(cmd_op, cmd_flag_index));
               pins_nxt.flag_space_select_n = 1'b0;
               tmr_load = 1'b1;
               tmr_val = dpsem_cnt(`DPSEM_SETUP_CYC);
               if (cmd_op == dpsem_pkg::dpsem_poll) begin
                  state_nxt = st_rsetup;
               end else begin
                  // Acquire writes zero; release and init write one
                  pins_nxt.wdata = {15'h0000, cmd_op != dpsem_pkg::dpsem_acquire};
                  pins_nxt.data_oe = 1'b1;
                  state_nxt = st_wsetup;
               end
            end
         end
         st_wsetup: begin
            if (tmr_done) begin
               pins_nxt.write_n = 1'b0;
               tmr_load = 1'b1;
               tmr_val = dpsem_cnt(`DPSEM_PULSE_CYC);
               state_nxt = st_wpulse;
            end
         end
         st_wpulse: begin
            if (tmr_done) begin
               pins_nxt.write_n = 1'b1;
               tmr_load = 1'b1;
               tmr_val = dpsem_cnt(`DPSEM_GAP_CYC);
               state_nxt = st_wgap;
            end
         end
         st_wgap: begin
            if (tmr_done) begin
               pins_nxt.data_oe = 1'b0;
               tmr_load = 1'b1;
               if (op_r == dpsem_pkg::dpsem_acquire) begin
                  // Read back after writing, never before
                  pins_nxt.flag_space_select_n = 1'b1;
                  tmr_val = dpsem_cnt(`DPSEM_GAP_CYC);
                  state_nxt = st_rgap;
               end else if (op_r == dpsem_pkg::dpsem_init && idx_r != 3'h7) begin
                  idx_nxt = idx_r + 3'h1;
                  pins_nxt.addr = dpsem_flag_addr(idx_r + 3'h1);
                  pins_nxt.data_oe = 1'b1;
                  tmr_val = dpsem_cnt(`DPSEM_SETUP_CYC);
                  state_nxt = st_wsetup;
               end else begin
                  pins_nxt.flag_space_select_n = 1'b1;
                  granted_nxt = 1'b0;
                  state_nxt = st_done;
               end
            end
         end
         st_rgap: begin
            if (tmr_done) begin
               pins_nxt.flag_space_select_n = 1'b0;
               pins_nxt.output_enable_n = 1'b0;
               tmr_load = 1'b1;
               tmr_val = dpsem_cnt(`DPSEM_PULSE_CYC);
               state_nxt = st_rsample;
            end
         end
         st_rsetup: begin
            if (tmr_done) begin
               pins_nxt.output_enable_n = 1'b0;
               tmr_load = 1'b1;
               tmr_val = dpsem_cnt(`DPSEM_PULSE_CYC);
               state_nxt = st_rsample;
            end
         end
         st_rsample: begin
            if (tmr_done) begin
               rdata_nxt = data_in;
               granted_nxt = !data_in[0];
               pins_nxt.output_enable_n = 1'b1;
               pins_nxt.flag_space_select_n = 1'b1;
               state_nxt = st_done;
            end
         end
         st_done: begin
            done_nxt = 1'b1;
            state_nxt = st_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= st_idle;
         pins_r <= '{flag_space_select_n: 1'b1, array_select_n: 1'b1, output_enable_n: 1'b1,
                     write_n: 1'b1, addr: 13'h0000, wdata: 16'h0000, data_oe: 1'b0};
         op_r <= dpsem_pkg::dpsem_acquire;
         idx_r <= 3'h0;
         rdata_r <= 16'h0000;
         ready_r <= 1'b0;
         done_r <= 1'b0;
         granted_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pins_r <= pins_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         done_r <= done_nxt;
         granted_r <= granted_nxt;
      end
   end

   assign cmd_ready = ready_r;
   assign done_pulse = done_r;
   assign done_granted = granted_r;
   assign done_rdata = rdata_r;
   assign flag_space_select_n = pins_r.flag_space_select_n;
   assign array_select_n = pins_r.array_select_n;
   assign output_enable_n = pins_r.output_enable_n;
   assign write_n = pins_r.write_n;
   assign addr = pins_r.addr;
   assign data_out = pins_r.wdata;
   assign data_oe = pins_r.data_oe;
endmodule // dpsem_host

// ### tb/dpsem_flag_model.sv
// Behavioural model of the shared flag space, far side driven by the bench
`timescale 1ns/100ps
module dpsem_flag_model (
   input wire logic core_clk,
   input wire dpsem_pkg::dpsem_pins_s pins,
   input wire logic b_we,
   input wire logic [2:0] b_idx,
   input wire logic b_v,
   output logic b_view,
   output logic [15:0] data_in
);
   logic [1:0] own [8];
   logic [7:0] rq [3];
   logic lat = 1'b0;
   logic rd = 1'b0;
   initial begin
      for (int i = 0; i < 8; i++) own[i] = 2'h0;
      rq[1] = 8'hff;
      rq[2] = 8'hff;
      data_in = 16'h0;
   end
   // Owner codes: 0 free, 1 host side, 2 far side
   task automatic wr(input logic [1:0] s, input logic [2:0] i, input logic v);
      rq[s][i] = v;
      if (own[i] == s && v) own[i] = rq[3 - s][i] ? 2'h0 : 2'(3 - s);
      else if (own[i] == 2'h0 && !v) own[i] = s;
   endtask
   // Host handled first, so a tie goes to the host side
   always @(posedge core_clk) begin
      if (!pins.flag_space_select_n && !pins.write_n) wr(2'h1, pins.addr[2:0], pins.wdata[0]);
      if (b_we) wr(2'h2, b_idx, b_v);
      if (!pins.flag_space_select_n && !pins.output_enable_n) begin
         if (!rd) lat = own[pins.addr[2:0]] != 2'h1;
         rd = 1'b1;
      end else rd = 1'b0;
      data_in <= rd ? {16{lat}} : ~data_in;
   end
   assign b_view = own[b_idx] != 2'h2;
endmodule // dpsem_flag_model

// ### tb/dpsem_host_checker.sv
// Pin protocol checker for the semaphore port controller
`timescale 1ns/100ps
`include "dpsem_cfg.svh"
module dpsem_host_checker (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic done_pulse,
   input wire logic flag_space_select_n,
   input wire logic array_select_n,
   input wire logic output_enable_n,
   input wire logic write_n,
   input wire logic [`DPSEM_ADDR_W-1:0] addr,
   input wire logic [`DPSEM_DATA_W-1:0] data_out,
   input wire logic data_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_arr; array_select_n; endproperty
   a_arr: assert property (p_arr) else $error("array select active");
   property p_wr; !write_n |-> data_oe && !flag_space_select_n && output_enable_n; endproperty
   a_wr: assert property (p_wr) else $error("write without select");
   property p_oe; !output_enable_n |-> !flag_space_select_n && write_n && !data_oe; endproperty
   a_oe: assert property (p_oe) else $error("read without select");
   property p_addr; !flag_space_select_n |-> addr[`DPSEM_ADDR_W-1:3] == 10'h0; endproperty
   a_addr: assert property (p_addr) else $error("high address bits set");
   property p_dat; data_oe |-> data_out[`DPSEM_DATA_W-1:1] == 15'h0; endproperty
   a_dat: assert property (p_dat) else $error("upper data bits set");
   property p_wlen; $fell(write_n) |=> !write_n ##1 write_n; endproperty
   a_wlen: assert property (p_wlen) else $error("write strobe length");
   property p_rlen; $fell(output_enable_n) |=> !output_enable_n ##1 output_enable_n; endproperty
   a_rlen: assert property (p_rlen) else $error("read strobe length");
   property p_poll; $rose(output_enable_n) |-> flag_space_select_n; endproperty
   a_poll: assert property (p_poll) else $error("select held between reads");
   property p_idle; cmd_ready |-> flag_space_select_n && output_enable_n && write_n; endproperty
   a_idle: assert property (p_idle) else $error("pins busy while idle");
   property p_acc; cmd_valid && cmd_ready |=> !flag_space_select_n && !cmd_ready; endproperty
   a_acc: assert property (p_acc) else $error("no cycle after accept");
   property p_done; done_pulse |=> !done_pulse && cmd_ready; endproperty
   a_done: assert property (p_done) else $error("done not one cycle");
endmodule // dpsem_host_checker

// ### tb/dpsem_host_test.sv
// Self-checking bench for the semaphore port controller
`timescale 1ns/100ps
`include "dpsem_cfg.svh"
module dpsem_host_test;
   logic core_clk, sys_rst, cmd_valid, b_we, b_v, b_view, cmd_ready, done_pulse, done_granted;
   logic flag_space_select_n, array_select_n, output_enable_n, write_n, data_oe;
   dpsem_pkg::dpsem_cmd_e cmd_op;
   logic [2:0] cmd_flag_index, b_idx, k, off;
   logic [15:0] done_rdata, data_out, data_in;
   logic [12:0] addr;
   dpsem_pkg::dpsem_pins_s pins;
   int n_fail = 0;
   int checks = 0;
   assign pins = {flag_space_select_n, array_select_n, output_enable_n, write_n, addr, data_out, data_oe};
   dpsem_host dut (.core_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_flag_index, .cmd_ready, .done_pulse,
      .done_granted, .done_rdata, .flag_space_select_n, .array_select_n, .output_enable_n, .write_n,
      .addr, .data_out, .data_oe, .data_in);
   dpsem_flag_model u_far (.core_clk, .pins, .b_we, .b_idx, .b_v, .b_view, .data_in);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic end_of_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Expected word on a read: all zeros when held by this side
   function automatic logic [15:0] rword(input logic g);
      return g ? 16'h0000 : 16'hffff;
   endfunction
   task automatic run(input dpsem_pkg::dpsem_cmd_e op, input logic [2:0] i, input logic g);
      int n;
      n = 0;
      do @(posedge core_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_flag_index <= i;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      do begin
         @(posedge core_clk);
         n++;
      end while (done_pulse !== 1'b1 && n < 100);
      if (n >= 100) n_fail++;
      chk({15'h0, done_granted}, {15'h0, g});
      if (op == dpsem_pkg::dpsem_acquire || op == dpsem_pkg::dpsem_poll) chk(done_rdata, rword(g));
   endtask
   task automatic bw(input logic [2:0] i, input logic v);
      @(posedge core_clk);
      b_we <= 1'b1;
      b_idx <= i;
      b_v <= v;
      @(posedge core_clk);
      b_we <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      end_of_test;
   end
   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = dpsem_pkg::dpsem_init;
      cmd_flag_index = 3'h0;
      b_we = 1'b0;
      b_idx = 3'h0;
      b_v = 1'b1;
      void'($urandom(95328));
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      off = 3'($urandom);
      run(dpsem_pkg::dpsem_init, 3'($urandom), 1'b0);
      for (int j = 0; j < 8; j++) bw(3'(j), 1'b1);
      for (int j = 0; j < 8; j++) begin
         k = 3'(j) + off;
         run(dpsem_pkg::dpsem_acquire, k, 1'b1);
         bw(k, 1'b0);
         chk({15'h0, b_view}, 16'h1);
         run(dpsem_pkg::dpsem_poll, k, 1'b1);
         run(dpsem_pkg::dpsem_release, k, 1'b0);
         chk({15'h0, b_view}, 16'h0);
         run(dpsem_pkg::dpsem_acquire, k, 1'b0);
         bw(k, 1'b1);
         run(dpsem_pkg::dpsem_poll, k, 1'b1);
         run(dpsem_pkg::dpsem_release, k, 1'b0);
         run(dpsem_pkg::dpsem_poll, k, 1'b0);
      end
      end_of_test;
   end
endmodule // dpsem_host_test
bind dpsem_host dpsem_host_checker u_chk (.core_clk, .sys_rst, .cmd_valid, .cmd_ready, .done_pulse,
   .flag_space_select_n, .array_select_n, .output_enable_n, .write_n, .addr, .data_out, .data_oe);
